// ---- mip_pkg.sv ----
package mip_pkg;

   // Word widths of the data path.
   localparam int WORD_W = 16;
   localparam int ACC_W = 36;
   localparam int EXT_W = 4;
   localparam int LC_W = 13;
   localparam int IMM7_W = 7;
   localparam int SHORT_W = 6;
   localparam int CNT_W = 5;

   // Base cycle counts of each instruction form.
   localparam logic [CNT_W-1:0] CYC_IMM7 = 5'h02;
   localparam logic [CNT_W-1:0] CYC_IMM16 = 5'h04;
   localparam logic [CNT_W-1:0] CYC_PMEM = 5'h08;
   localparam logic [CNT_W-1:0] CYC_PERIPH = 5'h02;
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;

   // Program words taken by each form, before extension words.
   localparam logic [1:0] WORDS_ONE = 2'h1;
   localparam logic [1:0] WORDS_TWO = 2'h2;

   // Saturation constants and the one-filled page of the short move.
   localparam logic [WORD_W-1:0] SAT_POS = 16'h7FFF;
   localparam logic [WORD_W-1:0] SAT_NEG = 16'h8000;
   localparam logic [WORD_W-SHORT_W-1:0] PAGE_ONES = 10'h3FF;
   localparam logic [WORD_W-1:0] LOW_ZERO = 16'h0000;
   localparam logic [WORD_W-1:0] PTR_STEP = 16'h0001;

   typedef enum logic [2:0] {
      OP_IMM7 = 3'h0,
      OP_IMM16 = 3'h1,
      OP_PM_RD = 3'h2,
      OP_PM_WR = 3'h3,
      OP_PP_RD = 3'h4,
      OP_PP_WR = 3'h5
   } mip_op_t;

   typedef enum logic [2:0] {
      R_A = 3'h0,
      R_B = 3'h1,
      R_A1 = 3'h2,
      R_B1 = 3'h3,
      R_A0 = 3'h4,
      R_B0 = 3'h5,
      R_X0 = 3'h6,
      R_LC = 3'h7
   } mip_reg_t;

   // Gray codes along idle, run, finish.
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN = 2'h1,
      ST_LAST = 2'h3
   } mip_state_t;

endpackage

// ---- mip_sat_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module mip_sat_unit #(
   parameter int ACC_W = 36,
   parameter int WORD_W = 16
) (
   input wire logic [ACC_W-1:0] acc,
   input wire logic full,
   input wire logic [WORD_W-1:0] part,
   output logic [WORD_W-1:0] word,
   output logic limited
);

   logic ext_used;

   // The extension is in use when the bits above the word's sign differ from it.
   assign ext_used = ~((&acc[ACC_W-1:WORD_W*2-1]) | ~(|acc[ACC_W-1:WORD_W*2-1]));
   // Only a whole accumulator is limited; a single word register passes untouched.
   assign limited = full & ext_used;
   always_comb begin
      if (!full) begin
         word = part;
      end else if (ext_used) begin
         word = acc[ACC_W-1] ? mip_pkg::SAT_NEG : mip_pkg::SAT_POS;
      end else begin
         word = acc[WORD_W*2-1:WORD_W];
      end
   end

endmodule
`default_nettype wire

// ---- mip_exec_unit.sv ----
// Contract
// (RULE_01) A 7-bit immediate into an accumulator lands sign extended with the low word cleared.
// (RULE_02) A 16-bit immediate into a register takes four cycles and two program words.
// (RULE_03) Software loads the loop counter only with values that fit in 13 bits.
// (RULE_04) The program-memory move carries a data register to or a word from program memory.
// (RULE_05) A whole accumulator with its extension in use is stored as a saturation constant.
// (RULE_06) A single accumulator word used as source is never saturated.
// (RULE_07) Saturation sets a sticky limit flag that only software clears.
// (RULE_08) A word into a whole accumulator copies bit 15 upward and appends sixteen zeros.
// (RULE_09) A write to an accumulator upper word alone changes only that word.
// (RULE_10) A program-memory read takes eight cycles plus waits, one word, and is signed.
// (RULE_11) The program-memory pointer is post-incremented by one or by the offset.
// (RULE_12) A program-memory write stores the register word at the pointer in eight cycles; the code adds the PM_WAIT cycles here too, as for reads.
// (RULE_13) The short move reads or writes one of the top 64 data words from a register or immediate.
// (RULE_14) The short move address is the 6-bit address with all upper bits set to one.
// (RULE_15) Short move accesses are flagged as peripheral register space.
// (RULE_16) The short move takes two cycles plus extra address cycles and one word plus extensions.
// (RULE_17) Immediate loads leave the condition flags unchanged.
`timescale 1ns/1ps
`default_nettype none
module mip_exec_unit #(
   parameter int WAIT_W = 3,
   parameter int EA_W = 2
) (
   input wire logic CORE_CLK,
   input wire logic ARST_N,
   input wire logic START,
   input wire logic [2:0] OPCODE,
   input wire logic [2:0] DST_SEL,
   input wire logic [2:0] SRC_SEL,
   input wire logic SRC_IS_IMM,
   input wire logic [15:0] IMM,
   input wire logic [5:0] SHORT_ADDR,
   input wire logic [EA_W-1:0] EA_CYCLES,
   input wire logic [EA_W-1:0] EA_WORDS,
   input wire logic [WAIT_W-1:0] PM_WAIT,
   input wire logic [15:0] PTR_IN,
   input wire logic [15:0] OFS_IN,
   input wire logic POST_BY_OFS,
   input wire logic LIMIT_CLR,
   input wire logic [15:0] PM_RDATA,
   input wire logic [15:0] DM_RDATA,
   output logic BUSY,
   output logic DONE,
   output logic [35:0] ACC_A,
   output logic [35:0] ACC_B,
   output logic [15:0] X0_REG,
   output logic [12:0] LC_REG,
   output logic LIMIT_FLAG,
   output logic [3:0] PROG_WORDS,
   output logic [15:0] PM_ADDR,
   output logic [15:0] PM_WDATA,
   output logic PM_RE,
   output logic PM_WE,
   output logic [15:0] DM_ADDR,
   output logic [15:0] DM_WDATA,
   output logic DM_RE,
   output logic DM_WE,
   output logic PERIPH_SEL,
   output logic [15:0] PTR_OUT,
   output logic PTR_WE
);

   mip_pkg::mip_state_t state_r;
   mip_pkg::mip_op_t op_r;
   mip_pkg::mip_reg_t dst_r, src_r;
   logic [mip_pkg::CNT_W-1:0] cnt_r;
   logic [15:0] imm_r, ptr_r, ofs_r;
   logic [5:0] sa_r;
   logic by_ofs_r, src_imm_r, start_ok, commit, is_rd, is_wr, is_pm, is_imm, lim, l_nxt;
   logic [35:0] acc_a_r, acc_b_r, sat_acc;
   logic [15:0] x0_r, rd_word, src_part, wr_word;
   logic [12:0] lc_r;
   logic [15:0] sat_word;
   logic l_flag_r, ptr_we_r;
   logic [15:0] ptr_out_r;
   logic [3:0] words_r;
   logic imm_store;

   // Cycle count of a form, with program waits and address extras added.
   function automatic logic [mip_pkg::CNT_W-1:0] op_cycles(input logic [2:0] op,
         input logic [WAIT_W-1:0] wt, input logic [EA_W-1:0] ea);
      case (op)
         mip_pkg::OP_IMM7: op_cycles = mip_pkg::CYC_IMM7;
         mip_pkg::OP_IMM16: op_cycles = mip_pkg::CYC_IMM16;
         // (RULE_10) eight plus waits
         mip_pkg::OP_PM_RD, mip_pkg::OP_PM_WR:
            op_cycles = mip_pkg::CYC_PMEM + mip_pkg::CNT_W'(wt);
         default: op_cycles = mip_pkg::CYC_PERIPH + mip_pkg::CNT_W'(ea);
      endcase
   endfunction

   // A word widened into a whole accumulator.
   function automatic logic [35:0] widen(input logic [15:0] w);
      widen = {{mip_pkg::EXT_W{w[15]}}, w, mip_pkg::LOW_ZERO};
   endfunction

   assign start_ok = START && (state_r == mip_pkg::ST_IDLE);
   assign commit = (state_r != mip_pkg::ST_IDLE) && (cnt_r == '0);
   assign is_imm = (op_r == mip_pkg::OP_IMM7) || (op_r == mip_pkg::OP_IMM16);
   assign is_pm = (op_r == mip_pkg::OP_PM_RD) || (op_r == mip_pkg::OP_PM_WR);
   assign is_wr = (op_r == mip_pkg::OP_PM_WR) || (op_r == mip_pkg::OP_PP_WR);
   assign is_rd = !is_wr;

   // Sequencer: one state step per cycle, finishing when the count runs out.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_r <= mip_pkg::ST_IDLE;
         cnt_r <= '0;
      end else begin
         case (state_r)
            mip_pkg::ST_IDLE: begin
               if (START) begin
                  // (RULE_02) cycle count per form
                  cnt_r <= op_cycles(OPCODE, PM_WAIT, EA_CYCLES) - mip_pkg::CNT_ONE;
                  state_r <= mip_pkg::ST_RUN;
               end
            end
            mip_pkg::ST_RUN: begin
               cnt_r <= cnt_r - mip_pkg::CNT_ONE;
               if (cnt_r == mip_pkg::CNT_ONE) begin
                  state_r <= mip_pkg::ST_LAST;
               end
            end
            default: begin
               state_r <= mip_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Operands are latched at the start so inputs may move during the instruction.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         op_r <= mip_pkg::OP_IMM7;
         dst_r <= mip_pkg::R_X0;
         src_r <= mip_pkg::R_X0;
         imm_r <= '0;
         sa_r <= '0;
         ptr_r <= '0;
         ofs_r <= '0;
         by_ofs_r <= 1'b0;
         src_imm_r <= 1'b0;
      end else if (start_ok) begin
         op_r <= mip_pkg::mip_op_t'(OPCODE);
         dst_r <= mip_pkg::mip_reg_t'(DST_SEL);
         src_r <= mip_pkg::mip_reg_t'(SRC_SEL);
         imm_r <= IMM;
         sa_r <= SHORT_ADDR;
         ptr_r <= PTR_IN;
         ofs_r <= OFS_IN;
         by_ofs_r <= POST_BY_OFS;
         src_imm_r <= SRC_IS_IMM;
      end
   end

   // Word count grows by the extension words of the short move.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         words_r <= '0;
      end else if (start_ok) begin
         // (RULE_16) words with extensions
         if (OPCODE == mip_pkg::OP_PP_RD || OPCODE == mip_pkg::OP_PP_WR) begin
            words_r <= 4'(mip_pkg::WORDS_ONE) + 4'(EA_WORDS);
         end else if (OPCODE == mip_pkg::OP_IMM16) begin
            words_r <= 4'(mip_pkg::WORDS_TWO);
         end else begin
            words_r <= 4'(mip_pkg::WORDS_ONE);
         end
      end
   end

   // Source word for stores, from the accumulators or the plain registers.
   always_comb begin
      case (src_r)
         mip_pkg::R_B, mip_pkg::R_B1: src_part = acc_b_r[31:16];
         mip_pkg::R_A0: src_part = acc_a_r[15:0];
         mip_pkg::R_B0: src_part = acc_b_r[15:0];
         mip_pkg::R_X0: src_part = x0_r;
         mip_pkg::R_LC: src_part = 16'(lc_r);
         default: src_part = acc_a_r[31:16];
      endcase
   end
   assign sat_acc = (src_r == mip_pkg::R_B) ? acc_b_r : acc_a_r;

   // (RULE_05) saturating store path
   mip_sat_unit #(.ACC_W(mip_pkg::ACC_W), .WORD_W(mip_pkg::WORD_W)) u_sat (
      .acc(sat_acc),
      // (RULE_06) only whole accumulators limit
      .full(src_r == mip_pkg::R_A || src_r == mip_pkg::R_B),
      .part(src_part),
      .word(sat_word),
      .limited(lim)
   );
   // Only the short write can carry an immediate; every other store goes through the limiter.
   assign imm_store = (op_r == mip_pkg::OP_PP_WR) && src_imm_r;
   assign wr_word = imm_store ? imm_r : sat_word;

   // Value headed for a register on load forms.
   always_comb begin
      case (op_r)
         mip_pkg::OP_IMM7: rd_word = 16'(signed'(imm_r[mip_pkg::IMM7_W-1:0]));
         mip_pkg::OP_PM_RD: rd_word = PM_RDATA;
         mip_pkg::OP_PP_RD: rd_word = DM_RDATA;
         default: rd_word = imm_r;
      endcase
   end

   // Memory strobes: reads one cycle ahead of the finish, writes in the finish cycle.
   // (RULE_04) program memory access
   assign PM_ADDR = ptr_r;
   assign PM_WDATA = wr_word;
   assign PM_RE = (op_r == mip_pkg::OP_PM_RD) && BUSY && (cnt_r == mip_pkg::CNT_ONE);
   // (RULE_12) store at the pointer
   assign PM_WE = (op_r == mip_pkg::OP_PM_WR) && commit;
   // (RULE_14) one-filled short address
   assign DM_ADDR = {mip_pkg::PAGE_ONES, sa_r};
   assign DM_WDATA = wr_word;
   // (RULE_13) one peripheral word
   assign DM_RE = (op_r == mip_pkg::OP_PP_RD) && BUSY && (cnt_r == mip_pkg::CNT_ONE);
   assign DM_WE = (op_r == mip_pkg::OP_PP_WR) && commit;
   // (RULE_15) peripheral space select
   assign PERIPH_SEL = DM_RE || DM_WE;

   // Register writeback at the finish of a load form.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         acc_a_r <= '0;
         acc_b_r <= '0;
         x0_r <= '0;
         lc_r <= '0;
      end else if (commit && is_rd) begin
         case (dst_r)
            // (RULE_01) (RULE_08) widen into accumulator
            mip_pkg::R_A: acc_a_r <= widen(rd_word);
            mip_pkg::R_B: acc_b_r <= widen(rd_word);
            // (RULE_09) upper word only
            mip_pkg::R_A1: acc_a_r[31:16] <= rd_word;
            mip_pkg::R_B1: acc_b_r[31:16] <= rd_word;
            mip_pkg::R_A0: acc_a_r[15:0] <= rd_word;
            mip_pkg::R_B0: acc_b_r[15:0] <= rd_word;
            // (RULE_03) upper bits dropped, software keeps within range
            mip_pkg::R_LC: lc_r <= rd_word[mip_pkg::LC_W-1:0];
            default: x0_r <= rd_word;
         endcase
      end
   end

   // (RULE_07) sticky limit, set beats clear
   // (RULE_17) immediates never reach this path
   assign l_nxt = (commit && is_wr && !imm_store && lim) ? 1'b1 : (LIMIT_CLR ? 1'b0 : l_flag_r);
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         l_flag_r <= 1'b0;
      end else begin
         l_flag_r <= l_nxt;
      end
   end

   // The pointer update is handed out one cycle after the finish cycle of the access.
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ptr_out_r <= '0;
         ptr_we_r <= 1'b0;
      end else begin
         ptr_we_r <= commit && is_pm;
         if (commit && is_pm) begin
            // (RULE_11) post-increment
            ptr_out_r <= ptr_r + (by_ofs_r ? ofs_r : mip_pkg::PTR_STEP);
         end
      end
   end

   assign BUSY = (state_r != mip_pkg::ST_IDLE);
   assign DONE = commit;
   assign ACC_A = acc_a_r;
   assign ACC_B = acc_b_r;
   assign X0_REG = x0_r;
   assign LC_REG = lc_r;
   assign LIMIT_FLAG = l_flag_r;
   assign PROG_WORDS = words_r;
   assign PTR_OUT = ptr_out_r;
   assign PTR_WE = ptr_we_r;

   sequence s_start_imm16;
      start_ok && OPCODE == mip_pkg::OP_IMM16;
   endsequence
   sequence s_start_pm0;
      start_ok && (OPCODE == mip_pkg::OP_PM_RD || OPCODE == mip_pkg::OP_PM_WR) && PM_WAIT == '0;
   endsequence

   property p_imm16_len;
      @(posedge CORE_CLK) disable iff (!ARST_N)
      s_start_imm16 |=> (BUSY && !DONE) [*3] ##1 DONE ##1 PROG_WORDS == 4'h2;
   endproperty
   a_imm16_len: assert property (p_imm16_len) else $error("immediate load length wrong"); // RULE_02
   property p_pm_len;
      @(posedge CORE_CLK) disable iff (!ARST_N)
      s_start_pm0 |=> !DONE ##6 !DONE ##1 DONE;
   endproperty
   a_pm_len: assert property (p_pm_len) else $error("program move length wrong"); // RULE_10
   property p_imm7_acc;
      @(posedge CORE_CLK) disable iff (!ARST_N)
      DONE && op_r == mip_pkg::OP_IMM7 && dst_r == mip_pkg::R_A |=>
         ACC_A == {{13{$past(imm_r[6])}}, $past(imm_r[6:0]), 16'h0000};
   endproperty
   a_imm7_acc: assert property (p_imm7_acc) else $error("short immediate not extended"); // RULE_01
   property p_sat;
      @(posedge CORE_CLK) disable iff (!ARST_N)
      PM_WE && src_r == mip_pkg::R_A && (ACC_A[35:31] != 5'h00 && ACC_A[35:31] != 5'h1F) |->
         PM_WDATA == (ACC_A[35] ? 16'h8000 : 16'h7FFF) ##1 LIMIT_FLAG;
   endproperty
   a_sat: assert property (p_sat) else $error("saturation or limit flag missing"); // RULE_05
   property p_nosat;
      @(posedge CORE_CLK) disable iff (!ARST_N)
      (PM_WE || (DM_WE && !src_imm_r)) && src_r == mip_pkg::R_A1 |->
         wr_word == ACC_A[31:16] ##1 LIMIT_FLAG == ($past(LIMIT_FLAG) && !$past(LIMIT_CLR));
   endproperty
   a_nosat: assert property (p_nosat) else $error("word source was limited"); // RULE_06
   property p_sticky;
      @(posedge CORE_CLK) disable iff (!ARST_N)
      LIMIT_FLAG && !LIMIT_CLR |=> LIMIT_FLAG;
   endproperty
   a_sticky: assert property (p_sticky) else $error("limit flag dropped"); // RULE_07
   property p_widen;
      @(posedge CORE_CLK) disable iff (!ARST_N)
      DONE && op_r == mip_pkg::OP_PM_RD && dst_r == mip_pkg::R_B |=>
         ACC_B == {{4{$past(PM_RDATA[15])}}, $past(PM_RDATA), 16'h0000};
   endproperty
   a_widen: assert property (p_widen) else $error("accumulator not widened"); // RULE_08
   property p_upper;
      @(posedge CORE_CLK) disable iff (!ARST_N)
      DONE && is_rd && dst_r == mip_pkg::R_A1 |=>
         ACC_A[35:32] == $past(ACC_A[35:32]) && ACC_A[15:0] == $past(ACC_A[15:0]);
   endproperty
   a_upper: assert property (p_upper) else $error("upper word write touched others"); // RULE_09
   property p_post_inc;
      @(posedge CORE_CLK) disable iff (!ARST_N)
      DONE && is_pm |=> PTR_WE && PTR_OUT == $past(ptr_r) + ($past(by_ofs_r) ? $past(ofs_r) : 16'h0001);
   endproperty
   a_post_inc: assert property (p_post_inc) else $error("pointer not post-incremented"); // RULE_11
   property p_pp_addr;
      @(posedge CORE_CLK) disable iff (!ARST_N)
      DM_RE || DM_WE |-> DM_ADDR[15:6] == 10'h3FF && DM_ADDR[5:0] == sa_r && PERIPH_SEL;
   endproperty
   a_pp_addr: assert property (p_pp_addr) else $error("short address not one-filled"); // RULE_14
   property p_imm_flags;
      @(posedge CORE_CLK) disable iff (!ARST_N)
      DONE && is_imm && !LIMIT_CLR |=> LIMIT_FLAG == $past(LIMIT_FLAG);
   endproperty
   a_imm_flags: assert property (p_imm_flags) else $error("immediate load changed flags"); // RULE_17

endmodule
`default_nettype wire

// ---- mip_exec_unit_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic core_clk, arst_n, start, src_is_imm, post_by_ofs, limit_clr;
   logic [2:0] opcode, dst_sel, src_sel;
   logic [15:0] imm, ptr_in, ofs_in, pm_rdata, dm_rdata;
   logic [5:0] short_addr;
   logic [1:0] ea_cycles, ea_words;
   logic [2:0] pm_wait;
   logic busy, done, limit_flag, pm_re, pm_we, dm_re, dm_we, periph_sel, ptr_we;
   logic [35:0] acc_a, acc_b;
   logic [15:0] x0_reg, pm_addr, pm_wdata, dm_addr, dm_wdata, ptr_out;
   logic [12:0] lc_reg;
   logic [3:0] prog_words;
   // Values captured while an operation runs, for checks after it ends.
   logic seen_pm, seen_dm, cap_psel;
   logic [15:0] cap_pa, cap_pd, cap_da, cap_dd;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int cnt;

   mip_exec_unit dut (.CORE_CLK(core_clk), .ARST_N(arst_n), .START(start), .OPCODE(opcode),
      .DST_SEL(dst_sel), .SRC_SEL(src_sel), .SRC_IS_IMM(src_is_imm), .IMM(imm),
      .SHORT_ADDR(short_addr), .EA_CYCLES(ea_cycles), .EA_WORDS(ea_words), .PM_WAIT(pm_wait),
      .PTR_IN(ptr_in), .OFS_IN(ofs_in), .POST_BY_OFS(post_by_ofs), .LIMIT_CLR(limit_clr),
      .PM_RDATA(pm_rdata), .DM_RDATA(dm_rdata), .BUSY(busy), .DONE(done), .ACC_A(acc_a),
      .ACC_B(acc_b), .X0_REG(x0_reg), .LC_REG(lc_reg), .LIMIT_FLAG(limit_flag),
      .PROG_WORDS(prog_words), .PM_ADDR(pm_addr), .PM_WDATA(pm_wdata), .PM_RE(pm_re),
      .PM_WE(pm_we), .DM_ADDR(dm_addr), .DM_WDATA(dm_wdata), .DM_RE(dm_re), .DM_WE(dm_we),
      .PERIPH_SEL(periph_sel), .PTR_OUT(ptr_out), .PTR_WE(ptr_we));

   // The clock runs at 50 MHz.
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // A hung handshake is cut short well beyond the hundred or so cycles the tests need.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         final_report();
      end
   end

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Issue one instruction, count the cycles up to the done pulse and capture the strobes.
   // The poke raises start again mid-run, which must be ignored while busy.
   task automatic do_op(input logic [2:0] op, input logic [2:0] dst, input logic [2:0] src,
                        input logic poke);
      @(posedge core_clk);
      opcode <= op;
      dst_sel <= dst;
      src_sel <= src;
      start <= 1'b1;
      @(posedge core_clk);
      start <= 1'b0;
      cnt = 0;
      seen_pm = 1'b0;
      seen_dm = 1'b0;
      repeat (30) begin
         #1;
         cnt++;
         if (pm_re === 1'b1 || pm_we === 1'b1) begin
            seen_pm = 1'b1;
            cap_pa = pm_addr;
            cap_pd = pm_wdata;
         end
         if (dm_re === 1'b1 || dm_we === 1'b1) begin
            seen_dm = 1'b1;
            cap_da = dm_addr;
            cap_dd = dm_wdata;
            cap_psel = periph_sel;
         end
         if (done === 1'b1)
            break;
         @(posedge core_clk);
         start <= poke && cnt == 1;
      end
      // A poke is still high at this edge; drop it so no further instruction is taken.
      @(posedge core_clk);
      start <= 1'b0;
      #1;
   endtask

   // Immediate loads, with the short form sign extended and the loop counter form.
   task automatic test_imm();
      imm <= 16'h0047;
      do_op(mip_pkg::OP_IMM7, mip_pkg::R_A, mip_pkg::R_A, 1'b0);
      chk("imm7 cycles", 36'h2, 36'(cnt));
      chk("imm7 acc", 36'hFFFC70000, acc_a);
      chk("imm7 words", 36'h1, 36'(prog_words));
      imm <= 16'h1ABC;
      do_op(mip_pkg::OP_IMM16, mip_pkg::R_LC, mip_pkg::R_A, 1'b0);
      chk("imm16 cycles", 36'h4, 36'(cnt));
      chk("imm16 words", 36'h2, 36'(prog_words));
      chk("loop counter", 36'h1ABC, 36'(lc_reg));
      imm <= 16'h0000;
      do_op(mip_pkg::OP_IMM7, mip_pkg::R_A, mip_pkg::R_A, 1'b0);
      imm <= 16'h8000;
      do_op(mip_pkg::OP_IMM16, mip_pkg::R_A1, mip_pkg::R_A, 1'b0);
      chk("upper word only", 36'h080000000, acc_a);
      chk("flag after imm", 36'h0, 36'(limit_flag));
      $display("test_imm finished");
   endtask

   // Program memory read with wait cycles and offset post-increment.
   task automatic test_pm_read();
      ptr_in <= 16'h0077;
      ofs_in <= 16'h0003;
      post_by_ofs <= 1'b1;
      pm_wait <= 3'h2;
      pm_rdata <= 16'h8116;
      do_op(mip_pkg::OP_PM_RD, mip_pkg::R_B, mip_pkg::R_A, 1'b0);
      chk("pm read cycles", 36'hA, 36'(cnt));
      chk("pm read strobe", 36'h1, 36'(seen_pm));
      chk("pm read addr", 36'h0077, 36'(cap_pa));
      chk("pm read acc", 36'hF81160000, acc_b);
      chk("pm read words", 36'h1, 36'(prog_words));
      chk("ptr offset", 36'h007A, 36'(ptr_out));
      chk("ptr write", 36'h1, 36'(ptr_we));
      $display("test_pm_read finished");
   endtask

   // Program memory writes: whole accumulator limited, single word not, flag sticky.
   task automatic test_pm_write();
      ptr_in <= 16'h0100;
      post_by_ofs <= 1'b0;
      pm_wait <= 3'h0;
      do_op(mip_pkg::OP_PM_WR, mip_pkg::R_A, mip_pkg::R_A, 1'b0);
      chk("pm write cycles", 36'h8, 36'(cnt));
      chk("pm write addr", 36'h0100, 36'(cap_pa));
      chk("pm write limited", 36'h7FFF, 36'(cap_pd));
      chk("limit set", 36'h1, 36'(limit_flag));
      chk("ptr by one", 36'h0101, 36'(ptr_out));
      imm <= 16'h1234;
      do_op(mip_pkg::OP_IMM16, mip_pkg::R_X0, mip_pkg::R_A, 1'b0);
      chk("x0 load", 36'h1234, 36'(x0_reg));
      chk("flag kept by imm", 36'h1, 36'(limit_flag));
      @(posedge core_clk);
      limit_clr <= 1'b1;
      @(posedge core_clk);
      limit_clr <= 1'b0;
      #1;
      chk("limit cleared", 36'h0, 36'(limit_flag));
      // With the flag clear, a word source must leave it clear.
      do_op(mip_pkg::OP_PM_WR, mip_pkg::R_A1, mip_pkg::R_A1, 1'b0);
      chk("pm write word", 36'h8000, 36'(cap_pd));
      chk("no limit from word", 36'h0, 36'(limit_flag));
      $display("test_pm_write finished");
   endtask

   // Short peripheral moves with one-filled addresses and extra address cycles.
   task automatic test_periph();
      imm <= 16'h0040;
      do_op(mip_pkg::OP_IMM7, mip_pkg::R_A, mip_pkg::R_A, 1'b0);
      imm <= 16'h7FFF;
      do_op(mip_pkg::OP_IMM16, mip_pkg::R_A1, mip_pkg::R_A, 1'b0);
      short_addr <= 6'h24;
      ea_cycles <= 2'h1;
      ea_words <= 2'h1;
      do_op(mip_pkg::OP_PP_WR, mip_pkg::R_A, mip_pkg::R_A, 1'b0);
      chk("pp write cycles", 36'h3, 36'(cnt));
      chk("pp write words", 36'h2, 36'(prog_words));
      chk("pp addr", 36'hFFE4, 36'(cap_da));
      chk("pp neg limit", 36'h8000, 36'(cap_dd));
      chk("pp select", 36'h1, 36'(cap_psel));
      chk("pp limit flag", 36'h1, 36'(limit_flag));
      short_addr <= 6'h3F;
      ea_cycles <= 2'h0;
      ea_words <= 2'h0;
      src_is_imm <= 1'b1;
      imm <= 16'h0342;
      do_op(mip_pkg::OP_PP_WR, mip_pkg::R_A, mip_pkg::R_A, 1'b0);
      chk("pp imm addr", 36'hFFFF, 36'(cap_da));
      chk("pp imm data", 36'h0342, 36'(cap_dd));
      src_is_imm <= 1'b0;
      short_addr <= 6'h00;
      dm_rdata <= 16'h5555;
      do_op(mip_pkg::OP_PP_RD, mip_pkg::R_X0, mip_pkg::R_A, 1'b1);
      chk("pp read cycles", 36'h2, 36'(cnt));
      chk("pp read strobe", 36'h1, 36'(seen_dm));
      chk("pp read addr", 36'hFFC0, 36'(cap_da));
      chk("pp read data", 36'h5555, 36'(x0_reg));
      chk("start refused", 36'h0, 36'(busy));
      $display("test_periph finished");
   endtask

   // Every input is set at time zero, then reset is held for 20 cycles.
   initial begin
      arst_n = 1'b0;
      start = 1'b0;
      opcode = 3'h0;
      dst_sel = 3'h0;
      src_sel = 3'h0;
      src_is_imm = 1'b0;
      imm = 16'h0000;
      short_addr = 6'h00;
      ea_cycles = 2'h0;
      ea_words = 2'h0;
      pm_wait = 3'h0;
      ptr_in = 16'h0000;
      ofs_in = 16'h0000;
      post_by_ofs = 1'b0;
      limit_clr = 1'b0;
      pm_rdata = 16'h0000;
      dm_rdata = 16'h0000;
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      test_imm();
      test_pm_read();
      test_pm_write();
      test_periph();
      final_report();
   end
endmodule
`default_nettype wire
